// file: hw/muxed_external_bus_interface.sv
`timescale 1ns/1ns
`default_nettype none
module muxed_external_bus_interface
   import ext_bus_pkg::*;
(
   input  wire logic         ref_clk_in,
   input  wire logic         rst_in,
   input  wire logic [3:0]   reg_addr_in,
   input  wire logic [31:0]  reg_wdata_in,
   input  wire logic         reg_write_in,
   input  wire logic         reg_read_in,
   output logic [31:0]       reg_rdata_out,
   input  wire logic         sys_valid_in,
   input  wire sys_req_type  sys_req_in,
   output logic              sys_ready_out,
   output logic              sys_done_out,
   output logic [31:0]       sys_rdata_out,
   output logic              sys_error_out,
   output ext_pins_type      pins_out,
   input  wire logic [15:0]  ad_in,
   output logic              bus_clock_out
);
   typedef enum {st_idle, st_setup, st_ale, st_lhd, st_a2d, st_acc, st_ahd, st_gap} state_type;

   logic [31:0] general_control;
   logic [31:0] timing_control;
   state_type   state;
   logic [4:0]  div_cnt;
   logic [5:0]  phase_cnt;
   logic        busy;
   sys_req_type req;
   logic [1:0]  part;
   logic [31:0] rbuf;
   logic        last_read;
   logic        last_valid;

   // register fields
   wire       enable_bit = general_control[enable_pos];
   wire       wide_mode  = general_control[wide_pos];
   wire [2:0] div_code   = general_control[divider_lsb +: 3];
   wire [2:0] ale_field  = general_control[strobe_width_lsb +: 3];
   wire [4:0] acc_field  = timing_control[access_lsb +: 5];
   wire [2:0] ahd_field  = timing_control[hold_lsb +: 3];
   wire [3:0] w2x_field  = timing_control[after_write_lsb +: 4];
   wire [3:0] r2r_field  = timing_control[read_read_lsb +: 4];

   // divider ratio minus one; codes 11x fall back to undivided
   function automatic logic [4:0] div_last(input logic [2:0] code);
      case (code)
         3'h1:    div_last = 5'h01;
         3'h2:    div_last = 5'h03;
         3'h3:    div_last = 5'h07;
         3'h4:    div_last = 5'h0f;
         3'h5:    div_last = 5'h1f;
         default: div_last = 5'h00;
      endcase
   endfunction

   wire [4:0] ratio_last = div_last(div_code);
   wire       undivided  = (ratio_last == 5'h00);
   // bus clock high in first half; tick on every system clock when undivided, else its fall
   wire       half_point = (div_cnt == ((ratio_last >> 1) + 5'h01)) ? 1'b1 : 1'b0;
   wire       tick       = undivided ? 1'b1 : half_point;
   wire       div_wrap   = (div_cnt >= ratio_last);
   wire [4:0] next_div   = div_wrap ? 5'h00 : div_cnt + 5'h01;

   // request acceptance and window decode
   wire in_window  = (sys_req_in.addr[31:17] == window_base);
   wire take       = sys_valid_in && !busy;
   wire start_ok   = take && enable_bit && in_window;
   wire [2:0] bytes = (req.size == 2'h0) ? 3'h1 : (req.size == 2'h1) ? 3'h2 : 3'h4;
   wire [1:0] parts_last = wide_mode ? ((bytes > 3'h2) ? 2'h1 : 2'h0)
                                     : 2'(bytes - 3'h1);
   // byte address of current part
   // a halfword at offset two starts in the upper half of its word
   wire [16:0] part_addr = wide_mode ? {req.addr[16:2], req.addr[1] | part[0], 1'b0}
                                     : {req.addr[16:2], req.addr[1:0] + part};
   wire [15:0] ext_addr = wide_mode ? part_addr[16:1] : part_addr[15:0];
   wire [4:0]  lane     = wide_mode ? {req.addr[1] | part[0], 4'h0}
                                    : {req.addr[1:0] + part, 3'h0};
   wire [31:0] wshift   = req.wdata >> lane;
   wire [15:0] wdata16  = wshift[15:0];
   wire        is_last  = (part == parts_last);
   // idle gap after this access
   wire [3:0]  gap_len  = req.write ? w2x_field : 4'h0;

   // bus clock output divider, also drives tick phase
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         div_cnt <= 5'h00;
         bus_clock_out <= 1'b0;
      end else begin
         div_cnt <= next_div;
         bus_clock_out <= undivided ? ~bus_clock_out : (next_div <= (ratio_last >> 1));
      end
   end

   // register file; timing writes take effect at once, even in the middle of an access
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         general_control <= general_control_reset;
         timing_control  <= timing_control_reset;
      end else if (reg_write_in) begin
         if (reg_addr_in == general_control_offset)
            general_control <= reg_wdata_in & 32'h00070703;
         if (reg_addr_in == timing_control_offset)
            timing_control <= reg_wdata_in & 32'h0f00f7f8;
      end
   end

   // read data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge ref_clk_in) begin
      if (rst_in)
         reg_rdata_out <= 32'h00000000;
      else if (reg_read_in)
         reg_rdata_out <= (reg_addr_in == general_control_offset) ? general_control :
                          (reg_addr_in == timing_control_offset)  ? timing_control  :
                          32'h00000000;
   end

   // access sequencer; phase_cnt counts bus clocks left in a phase
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state <= st_idle;
         phase_cnt <= 6'h00;
         busy <= 1'b0;
         req <= '0;
         part <= 2'h0;
         rbuf <= 32'h00000000;
         last_read <= 1'b0;
         last_valid <= 1'b0;
         sys_done_out <= 1'b0;
         sys_error_out <= 1'b0;
         sys_rdata_out <= 32'h00000000;
         sys_ready_out <= 1'b0;
         pins_out <= '{ad_out: 16'h0000, ad_oe_n: 16'hffff, ale: 1'b0,
                       chip_select_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1};
      end else begin
         sys_done_out <= 1'b0;
         sys_error_out <= 1'b0;
         sys_ready_out <= !busy && !take;
         if (take && !start_ok) begin
            sys_done_out <= 1'b1; // disabled or out of window
            sys_error_out <= 1'b1;
         end else if (start_ok) begin
            busy <= 1'b1;
            req <= sys_req_in;
            part <= 2'h0;
            rbuf <= 32'h00000000;
         end
         if (busy && tick) begin
            case (state)
               st_idle: begin
                  if (last_valid && last_read && !req.write && r2r_field != 4'h0) begin
                     state <= st_gap;
                     phase_cnt <= {2'h0, r2r_field} - 6'h01;
                     last_valid <= 1'b0;
                  end else begin
                     state <= st_setup;
                     pins_out.chip_select_n <= 1'b0;
                     pins_out.ad_out <= ext_addr;
                     pins_out.ad_oe_n <= 16'h0000;
                     phase_cnt <= address_setup_time - 6'h01;
                  end
               end
               st_setup: if (phase_cnt == 6'h00) begin
                  state <= st_ale;
                  pins_out.ale <= 1'b1;
                  phase_cnt <= {3'h0, ale_field};
               end else phase_cnt <= phase_cnt - 6'h01;
               st_ale: if (phase_cnt == 6'h00) begin
                  state <= st_lhd;
                  pins_out.ale <= 1'b0;
                  phase_cnt <= latch_hold_time - 6'h01;
               end else phase_cnt <= phase_cnt - 6'h01;
               st_lhd: if (phase_cnt == 6'h00) begin
                  state <= st_a2d;
                  phase_cnt <= turnaround_time - 6'h01;
                  // low pins turn to data; upper pins keep address in narrow mode
                  pins_out.ad_oe_n <= wide_mode ? {16{req.write ? 1'b0 : 1'b1}}
                                    : {8'h00, {8{req.write ? 1'b0 : 1'b1}}};
                  if (req.write)
                     pins_out.ad_out <= wide_mode ? wdata16
                                     : {ext_addr[15:8], wdata16[7:0]};
               end else phase_cnt <= phase_cnt - 6'h01;
               st_a2d: if (phase_cnt == 6'h00) begin
                  state <= st_acc;
                  pins_out.read_strobe_n <= req.write;
                  pins_out.write_strobe_n <= !req.write;
                  phase_cnt <= {1'b0, acc_field};
               end else phase_cnt <= phase_cnt - 6'h01;
               st_acc: if (phase_cnt == 6'h00) begin
                  state <= st_ahd;
                  pins_out.read_strobe_n <= 1'b1;
                  pins_out.write_strobe_n <= 1'b1;
                  if (!req.write)
                     rbuf <= rbuf | ((wide_mode ? {16'h0000, ad_in}
                                      : {24'h000000, ad_in[7:0]}) << lane);
                  phase_cnt <= {3'h0, ahd_field};
               end else phase_cnt <= phase_cnt - 6'h01;
               st_ahd: if (phase_cnt == 6'h00) begin
                  pins_out.ad_oe_n <= 16'hffff;
                  pins_out.ale <= 1'b0;
                  last_read <= !req.write;
                  last_valid <= 1'b1;
                  if (gap_len != 4'h0) begin
                     state <= st_gap;
                     pins_out.chip_select_n <= 1'b1;
                     phase_cnt <= {2'h0, gap_len} - 6'h01;
                     last_valid <= 1'b0;
                  end else begin
                     state <= st_idle;
                     pins_out.chip_select_n <= 1'b1;
                     if (!is_last) part <= part + 2'h1;
                     else begin
                        busy <= 1'b0;
                        sys_done_out <= 1'b1;
                        sys_rdata_out <= rbuf;
                     end
                  end
               end else phase_cnt <= phase_cnt - 6'h01;
               st_gap: if (phase_cnt == 6'h00) begin
                  // after a write the part is finished here; a read-read gap
                  // precedes an access whose part was already advanced
                  if (req.write) begin
                     state <= st_idle; // controls stay inactive meanwhile
                     if (!is_last) part <= part + 2'h1;
                     else begin
                        busy <= 1'b0;
                        sys_done_out <= 1'b1;
                        sys_rdata_out <= rbuf;
                     end
                  end else begin
                     // start at once so the gap is exactly the field's count
                     state <= st_setup;
                     pins_out.chip_select_n <= 1'b0;
                     pins_out.ad_out <= ext_addr;
                     pins_out.ad_oe_n <= 16'h0000;
                     phase_cnt <= address_setup_time - 6'h01;
                  end
                  last_read <= 1'b0;
               end else phase_cnt <= phase_cnt - 6'h01;
               default: state <= st_idle;
            endcase
         end
      end
   end
endmodule // muxed_external_bus_interface
`default_nettype wire

// file: hw/ext_bus_pkg.sv
package ext_bus_pkg;
   localparam logic [3:0]  general_control_offset = 4'h0;
   localparam logic [3:0]  timing_control_offset  = 4'h4;
   localparam logic [31:0] general_control_reset  = 32'h00000000;
   localparam logic [31:0] timing_control_reset   = 32'h00000000;
   localparam int enable_pos       = 0;
   localparam int wide_pos         = 1;
   localparam int divider_lsb      = 8;
   localparam int strobe_width_lsb = 16;
   localparam int access_lsb       = 3;
   localparam int hold_lsb         = 8;
   localparam int after_write_lsb  = 12;
   localparam int read_read_lsb    = 24;
   // fixed phases, in bus clocks
   localparam logic [5:0] address_setup_time = 6'h01;
   localparam logic [5:0] latch_hold_time    = 6'h01;
   localparam logic [5:0] turnaround_time    = 6'h01;
   // system window base (address bits 31:17)
   localparam logic [14:0] window_base = 15'h3000;

   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic [1:0]  size;   // 0 byte, 1 half, 2 word
      logic [31:0] wdata;
   } sys_req_type;

   typedef struct packed {
      logic [15:0] ad_out;
      logic [15:0] ad_oe_n;
      logic        ale;
      logic        chip_select_n;
      logic        read_strobe_n;
      logic        write_strobe_n;
   } ext_pins_type;
endpackage

// file: tb/ext_bus_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ext_bus_asserts
   import ext_bus_pkg::*;
(
   input wire logic         ref_clk_in,
   input wire logic         rst_in,
   input wire logic         sys_ready_out,
   input wire logic         sys_done_out,
   input wire logic         sys_error_out,
   input wire ext_pins_type pins_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // pin sequencing; widths are judged by the bench for every divider
   ale_with_cs_a: assert property (pins_out.ale |-> !pins_out.chip_select_n)
      else $error("latch strobe without chip select");
   ale_drives_a: assert property (pins_out.ale |-> pins_out.ad_oe_n == 16'h0000)
      else $error("address not driven under latch strobe");
   ale_no_strobe_a: assert property (pins_out.ale |-> pins_out.read_strobe_n && pins_out.write_strobe_n)
      else $error("data strobe during latch strobe");
   read_release_a: assert property (!pins_out.read_strobe_n |-> pins_out.ad_oe_n[7:0] == 8'hff)
      else $error("pins driven during read");
   write_drive_a: assert property (!pins_out.write_strobe_n |-> pins_out.ad_oe_n[7:0] == 8'h00)
      else $error("write data not driven");
   setup_first_a: assert property ($fell(pins_out.chip_select_n) |-> !pins_out.ale)
      else $error("no address setup before latch strobe");
   strobe_gap_a: assert property ($fell(pins_out.read_strobe_n && pins_out.write_strobe_n)
      |-> !$past(pins_out.ale) && !$past(pins_out.ale, 2))
      else $error("hold or turnaround skipped");
   error_done_a: assert property (sys_error_out |-> sys_done_out)
      else $error("error without done");
   idle_quiet_a: assert property (sys_ready_out |-> pins_out.chip_select_n && !pins_out.ale
      && pins_out.read_strobe_n && pins_out.write_strobe_n)
      else $error("controls active while idle");
endmodule // ext_bus_asserts

bind muxed_external_bus_interface ext_bus_asserts chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
   .sys_ready_out(sys_ready_out), .sys_done_out(sys_done_out), .sys_error_out(sys_error_out),
   .pins_out(pins_out));
`default_nettype wire

// file: tb/ext_device_model.sv
`timescale 1ns/1ns
`default_nettype none
module ext_device_model
   import ext_bus_pkg::*;
#(
   parameter int valid_after = 2
)(
   input  wire logic         ref_clk_in,
   input  wire ext_pins_type pins_out,
   output logic [15:0]       ad_in
);
   logic [15:0] latched_addr = 16'h0000;
   logic [15:0] churn        = 16'h1234;
   int          rd_count     = 0;
   // external latch follows the pins while the strobe is high
   always @(posedge ref_clk_in) begin
      if (pins_out.ale) latched_addr <= pins_out.ad_out;
      rd_count <= pins_out.read_strobe_n ? 0 : rd_count + 1;
      churn    <= churn + 16'h9e37;
   end
   // slow part: data valid late; a moving pattern otherwise so stale values never match
   assign ad_in = (!pins_out.chip_select_n && !pins_out.read_strobe_n
                   && rd_count >= valid_after) ? ~latched_addr : churn;
endmodule // ext_device_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
   import ext_bus_pkg::*;
;
   logic         ref_clk_in, rst_in, reg_write_in, reg_read_in, sys_valid_in, sys_ready_out;
   logic         sys_done_out, sys_error_out, bus_clock_out, got_err;
   logic [3:0]   reg_addr_in;
   logic [31:0]  reg_wdata_in, reg_rdata_out, sys_rdata_out, got_data;
   sys_req_type  sys_req_in;
   ext_pins_type pins_out;
   logic [15:0]  ad_in, wr_ad, wr_oe;
   int           bad_count, tests_run, ale_run, ale_w, wr_run, wr_w, cs_run, cs_gap, g0;

   muxed_external_bus_interface dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
      .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .sys_valid_in(sys_valid_in),
      .sys_req_in(sys_req_in), .sys_ready_out(sys_ready_out), .sys_done_out(sys_done_out),
      .sys_rdata_out(sys_rdata_out), .sys_error_out(sys_error_out), .pins_out(pins_out),
      .ad_in(ad_in), .bus_clock_out(bus_clock_out));
   ext_device_model #(.valid_after(2)) dev (.ref_clk_in(ref_clk_in), .pins_out(pins_out),
      .ad_in(ad_in));

   initial begin
      ref_clk_in = 0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   // pulse widths and gaps in system clocks, seen at the pins
   always @(posedge ref_clk_in) begin
      ale_run <= pins_out.ale ? ale_run + 1 : 0;
      if (!pins_out.ale && ale_run != 0) ale_w <= ale_run;
      wr_run <= pins_out.write_strobe_n ? 0 : wr_run + 1;
      if (!pins_out.write_strobe_n) begin
         wr_ad <= pins_out.ad_out;
         wr_oe <= pins_out.ad_oe_n;
      end
      if (pins_out.write_strobe_n && wr_run != 0) wr_w <= wr_run;
      cs_run <= pins_out.chip_select_n ? cs_run + 1 : 0;
      if (!pins_out.chip_select_n && cs_run != 0) cs_gap <= cs_run;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      reg_write_in <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge ref_clk_in);
      reg_write_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      reg_read_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge ref_clk_in);
      reg_read_in <= 1'b0;
      @(negedge ref_clk_in);
      d = reg_rdata_out;
      @(posedge ref_clk_in);
   endtask

   // one request, waits for its done pulse under a bound
   task automatic sys_op(input logic w, input logic [31:0] a, d, input logic [1:0] sz);
      int n;
      sys_valid_in <= 1'b1;
      sys_req_in   <= '{addr: a, write: w, size: sz, wdata: d};
      @(posedge ref_clk_in);
      sys_valid_in <= 1'b0;
      n = 0;
      do begin
         @(negedge ref_clk_in);
         n++;
      end while (sys_done_out !== 1'b1 && n < 5000);
      if (n >= 5000) bad_count++;
      got_data = sys_rdata_out;
      got_err  = sys_error_out;
      @(posedge ref_clk_in);
   endtask

   task automatic t_regs();
      logic [31:0] v;
      reg_rd(4'h0, v); check(v, 32'h0);
      reg_rd(4'h4, v); check(v, 32'h0);
      reg_wr(4'h0, 32'hffffffff);
      reg_wr(4'h4, 32'hffffffff);
      reg_rd(4'h0, v); check(v, 32'h00070703);
      reg_rd(4'h4, v); check(v, 32'h0f00f7f8);
      reg_rd(4'h8, v); check(v, 32'h0);
   endtask

   task automatic t_errors();
      reg_wr(4'h0, 32'h0);
      sys_op(1'b0, 32'h60000000, 32'h0, 2'h0); check(got_err, 1'b1);
      reg_wr(4'h0, 32'h1);
      sys_op(1'b0, 32'h60020000, 32'h0, 2'h0); check(got_err, 1'b1);
   endtask

   // every divider code, 8-bit byte write; widths scale with the bus clock
   task automatic t_timing();
      int d;
      reg_wr(4'h4, 32'h00000220);
      for (int c = 0; c < 8; c++) begin
         d = (c > 5) ? 1 : (1 << c);
         reg_wr(4'h0, 32'h00020001 | (c << 8));
         sys_op(1'b1, 32'h60001234, 32'h000000a5, 2'h0);
         check(got_err, 1'b0);
         check(ale_w, 3 * d);
         check(wr_w, 5 * d);
         check(wr_ad, 16'h12a5);
         check(wr_oe, 16'h0000);
      end
   endtask

   task automatic t_reads();
      reg_wr(4'h4, 32'h00000018);
      reg_wr(4'h0, 32'h3);
      sys_op(1'b0, 32'h60000104, 32'h0, 2'h2); check(got_data, 32'hff7cff7d);
      reg_wr(4'h0, 32'h1);
      sys_op(1'b0, 32'h60000104, 32'h0, 2'h2); check(got_data, 32'hf8f9fafb);
   endtask

   // idle gaps between the two halves of a word
   task automatic t_idle();
      reg_wr(4'h0, 32'h3);
      reg_wr(4'h4, 32'h00000018);
      sys_op(1'b0, 32'h60000100, 32'h0, 2'h2);
      g0 = cs_gap;
      reg_wr(4'h4, 32'h05000018);
      sys_op(1'b0, 32'h60000100, 32'h0, 2'h2);
      check(cs_gap - g0, 5);
      reg_wr(4'h4, 32'h00000018);
      sys_op(1'b1, 32'h60000100, 32'h12345678, 2'h2);
      g0 = cs_gap;
      reg_wr(4'h4, 32'h00007018);
      sys_op(1'b1, 32'h60000100, 32'h12345678, 2'h2);
      check(cs_gap - g0, 7);
   endtask

   initial begin
      rst_in       = 1'b1;
      reg_write_in = 1'b0;
      reg_read_in  = 1'b0;
      reg_addr_in  = 4'h0;
      reg_wdata_in = 32'h0;
      sys_valid_in = 1'b0;
      sys_req_in   = '0;
      repeat (16) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      t_regs();
      t_errors();
      t_timing();
      t_reads();
      t_idle();
      end_of_test();
   end

   initial begin
      repeat (90000) @(posedge ref_clk_in);
      bad_count++;
      end_of_test();
   end
endmodule // tb
`default_nettype wire
